// >>> rtl/bhc_map.svh
// constants for the bus fault and halt control block
`ifndef BHC_MAP_SVH
`define BHC_MAP_SVH
`define BHC_CLK_NS        10
`define BHC_AS_NEG_NS     25
`define BHC_AS_NEG_CYC    ((`BHC_AS_NEG_NS + `BHC_CLK_NS - 1) / `BHC_CLK_NS)
`define BHC_RST_HALT_CYC  10
`define BHC_RST_OUT_CYC   124
`define BHC_FRAME_BYTES   14
`define BHC_PCSR_BYTES    6
`define BHC_VEC_BYTES     4
`define BHC_FAULT_VEC_ADDR 20'h00008
`define BHC_FC_SUPV_DATA  3'h5
`define BHC_FC_SUPV_PROG  3'h6
`endif

// >>> rtl/bhc_pkg.sv
// types shared by the bus fault and halt control block
package bhc_pkg;
  typedef struct packed {
    logic ack;
    logic fault;
    logic halt;
    logic rst;
  } bhc_pins_s;
  typedef struct packed {
    logic [19:0] addr;
    logic [7:0]  data;
    logic [2:0]  fc;
    logic        write;
    logic        rmw;
  } bhc_cyc_s;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WAIT,
    ST_FAULT,
    ST_RERUN,
    ST_DFAULT
  } bhc_state_e;
endpackage

// >>> rtl/bhc_insync.sv
// input sampler: bus handshake pins to active-high internal levels
`timescale 1ns/1ps
module bhc_insync import bhc_pkg::*; (
  input  wire logic      mclk_i,
  input  wire logic      rst_i,
  input  wire logic      transfer_acknowledge_n_i,
  input  wire logic      bus_fault_in_n_i,
  input  wire logic      halt_n_i,
  input  wire logic      reset_n_i,
  output bhc_pins_s      pins_o
);
  // one sample stage; inputs are valid internally one edge later
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pins_o <= '0;
    end else begin
      pins_o.ack   <= ~transfer_acknowledge_n_i;
      pins_o.fault <= ~bus_fault_in_n_i;
      pins_o.halt  <= ~halt_n_i;
      pins_o.rst   <= ~reset_n_i;
    end
  end
endmodule

// >>> rtl/bhc_rstline.sv
// reset line: external reset detection and reset-instruction drive
`timescale 1ns/1ps
`include "bhc_map.svh"
module bhc_rstline import bhc_pkg::*; (
  input  wire logic      mclk_i,
  input  wire logic      rst_i,
  input  bhc_pins_s      pins_i,
  input  wire logic      reset_insn_i,
  output logic           sys_rst_o,
  output logic           reset_n_o,
  output logic           reset_oe_o
);
  logic [3:0] hold_r;
  logic [6:0] drv_r;

  // reset plus halt held for the full count resets the processor
  always_ff @(posedge mclk_i) begin
    if (rst_i || reset_oe_o || !(pins_i.rst && pins_i.halt)) begin
      hold_r <= 4'h0;
    end else if (hold_r != 4'(`BHC_RST_HALT_CYC)) begin
      hold_r <= hold_r + 4'h1;
    end
  end

  // our own drive is ignored above, so the reset instruction cannot reset us
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sys_rst_o <= 1'b0;
    end else begin
      sys_rst_o <= (hold_r == 4'(`BHC_RST_HALT_CYC - 1));
    end
  end

  // reset instruction drives the shared line low for a fixed span
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      drv_r <= 7'h00;
    end else if (reset_insn_i && drv_r == 7'h00) begin
      drv_r <= 7'(`BHC_RST_OUT_CYC);
    end else if (drv_r != 7'h00) begin
      drv_r <= drv_r - 7'h01;
    end
  end

  assign reset_oe_o = (drv_r != 7'h00);
  assign reset_n_o  = 1'b0;
endmodule

// >>> rtl/bhc_ctrl.sv
// bus cycle termination, bus fault exception, re-run, halt and double fault
//
// What this block does
// - bus fault ends the current cycle at once, no acknowledge needed.
// - address strobe negates three clocks (25 ns rounded up to whole clocks) after fault recognition.
// - address and data float while the fault input stays asserted.
// - after fault negates: stack PC/SR, stack error data, fetch vector, run.
// - PC and SR stacked as for an interrupt, then access details.
// - new PC loaded from the fault vector, handler then starts.
// - fault with halt driven: end the cycle, float address and data.
// - in re-run, wait for halt release, repeat identical cycle.
// - read-modify-write never re-runs; fault plus halt gives the exception.
// - halt active means no bus cycles; halt inactive means normal running.
// - halt released until a cycle starts, then reasserted: one cycle only.
// - cycle finished with halt seen active floats address and data.
// - arbitration works while halted; it floats the control lines.
// - second fault before next instruction, stacking included, halts the part.
// - re-runs never count toward double fault; re-run repeats indefinitely.
// - fault before the first instruction after reset is a double fault.
// - only an external reset leaves the double fault halt.
// - reset line is two-way, driven by either party.
// - handshake inputs are sampled and valid internally one edge later.
// - reset with halt for ten clocks resets the processor fully.
`timescale 1ns/1ps
`include "bhc_map.svh"
module bhc_ctrl import bhc_pkg::*; (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // core request side
  input  wire logic        cyc_req_i,
  input  bhc_cyc_s         cyc_i,
  output logic             cyc_ack_o,
  output logic             cyc_done_o,
  output logic [7:0]       cyc_rdata_o,
  input  wire logic [31:0] exc_pc_i,
  input  wire logic [15:0] exc_sr_i,
  input  wire logic [15:0] exc_ir_i,
  input  wire logic [19:0] exc_sp_i,
  input  wire logic        insn_start_i,
  input  wire logic        reset_insn_i,
  output logic [31:0]      handler_pc_o,
  output logic             handler_go_o,
  output logic             dfault_o,
  output logic             core_rst_o,
  // arbitration
  input  wire logic        bus_req_i,
  output logic             bus_grant_o,
  // pins
  output logic [19:0]      addr_o,
  output logic             addr_oe_o,
  input  wire logic [7:0]  data_i,
  output logic [7:0]       data_o,
  output logic             data_oe_o,
  output logic [2:0]       fc_o,
  output logic             rw_o,
  output logic             address_strobe_n_o,
  output logic             ctl_oe_o,
  input  wire logic        transfer_acknowledge_n_i,
  input  wire logic        bus_fault_in_n_i,
  input  wire logic        halt_n_i,
  output logic             halt_n_o,
  output logic             halt_oe_o,
  input  wire logic        reset_n_i,
  output logic             reset_n_o,
  output logic             reset_oe_o
);
  bhc_pins_s   pins;
  logic        sys_rst;
  logic        rst_all;
  bhc_state_e  state_r;
  bhc_cyc_s    cur_r;
  bhc_cyc_s    next_cyc;
  logic        as_r;
  logic        drv_r;
  logic        rmw_wr_r;
  logic        rerun_r;
  logic [1:0]  cnt_r;
  logic        exc_r;
  logic [4:0]  exc_idx_r;
  logic        flt_flag_r;
  logic        boot_r;
  logic        grant_r;
  logic [19:0] flt_addr_r;
  logic [2:0]  flt_fc_r;
  logic        flt_wr_r;
  logic [15:0] flt_ir_r;
  logic [31:0] vec_r;
  logic        go_r;
  logic        done_r;
  logic        start;
  logic        end_ok;
  logic        last_exc;

  bhc_insync u_insync (
    .mclk_i                   (mclk_i),
    .rst_i                    (rst_i),
    .transfer_acknowledge_n_i (transfer_acknowledge_n_i),
    .bus_fault_in_n_i         (bus_fault_in_n_i),
    .halt_n_i                 (halt_n_i),
    .reset_n_i                (reset_n_i),
    .pins_o                   (pins)
  );

  bhc_rstline u_rstline (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .pins_i       (pins),
    .reset_insn_i (reset_insn_i),
    .sys_rst_o    (sys_rst),
    .reset_n_o    (reset_n_o),
    .reset_oe_o   (reset_oe_o)
  );

  // the whole control state restarts on either reset source
  assign rst_all    = rst_i | sys_rst;
  assign core_rst_o = sys_rst;

  // exception frame: pc, sr first, then ir, access address, access status
  function automatic logic [7:0] frame_byte(input logic [4:0] idx);
    logic [111:0] f;
    f = {11'h000, ~flt_wr_r, 1'b0, flt_fc_r, 12'h000, flt_addr_r,
         flt_ir_r, exc_sr_i, exc_pc_i};
    frame_byte = f[8*idx +: 8];
  endfunction

  // cycle for one step of the exception sequence
  function automatic bhc_cyc_s exc_cyc(input logic [4:0] idx);
    bhc_cyc_s c;
    c = '0;
    if (idx < 5'(`BHC_FRAME_BYTES)) begin
      c.addr  = exc_sp_i - 20'(idx) - 20'h00001;
      c.data  = frame_byte(idx);
      c.fc    = `BHC_FC_SUPV_DATA;
      c.write = 1'b1;
    end else begin
      c.addr  = `BHC_FAULT_VEC_ADDR + 20'(idx - 5'(`BHC_FRAME_BYTES));
      c.fc    = `BHC_FC_SUPV_PROG;
    end
    exc_cyc = c;
  endfunction

  assign next_cyc = exc_r ? exc_cyc(exc_idx_r) : cyc_i;

  // a cycle starts only with halt inactive and the bus not granted away
  assign start = (state_r == ST_IDLE) && !pins.halt && !grant_r
               && (exc_r || cyc_req_i);
  assign cyc_ack_o = start && !exc_r;

  // acknowledge completes the cycle unless a fault is seen with it or it ends the read half of a read-modify-write
  assign end_ok = (state_r == ST_WAIT) && pins.ack && !pins.fault
               && !(cur_r.rmw && !rmw_wr_r);
  assign last_exc = exc_idx_r == 5'(`BHC_FRAME_BYTES + `BHC_VEC_BYTES - 1);

  // main cycle sequencer
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (pins.fault) begin
            state_r <= ST_FAULT;
          end else if (end_ok) begin
            state_r <= ST_IDLE;
          end else if (pins.ack && cur_r.rmw && !rmw_wr_r) begin
            state_r <= ST_ADDR;
          end
        end
        ST_FAULT: begin
          // decide only after the strobe is gone and the fault input drops
          if (!as_r && !pins.fault) begin
            if (rerun_r) begin
              state_r <= ST_RERUN;
            end else if (flt_flag_r || boot_r) begin
              state_r <= ST_DFAULT;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_RERUN: begin
          // fault is gone already, so a halt release means a clean repeat
          if (!pins.halt && !grant_r) begin
            state_r <= ST_ADDR;
          end
        end
        ST_DFAULT: begin
          state_r <= ST_DFAULT;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // latched cycle descriptor; kept untouched so a re-run repeats it exactly
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      cur_r <= '0;
    end else if (start) begin
      cur_r <= next_cyc;
    end
  end

  // read-modify-write keeps the strobe through both halves
  always_ff @(posedge mclk_i) begin
    if (rst_all || start) begin
      rmw_wr_r <= 1'b0;
    end else if (state_r == ST_WAIT && pins.ack && !pins.fault && cur_r.rmw) begin
      rmw_wr_r <= 1'b1;
    end
  end

  // address strobe, with the delayed negation after a fault
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      as_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else if (state_r == ST_ADDR) begin
      as_r <= 1'b1;
    end else if (state_r == ST_WAIT && pins.fault) begin
      cnt_r <= 2'h1;
    end else if (end_ok) begin
      as_r <= 1'b0;
    end else if (state_r == ST_FAULT && as_r) begin
      if (cnt_r == 2'(`BHC_AS_NEG_CYC)) begin
        as_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end

  // re-run only when halt is seen with the fault and the cycle is not indivisible
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      rerun_r <= 1'b0;
    end else if (state_r == ST_WAIT && pins.fault) begin
      rerun_r <= pins.halt && !cur_r.rmw && !exc_r;
    end
  end

  // address and data drive; floated on fault, on halted completion, on grant
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      drv_r <= 1'b0;
    end else if (grant_r) begin
      drv_r <= 1'b0;
    end else if (start || (state_r == ST_RERUN && !pins.halt)) begin
      drv_r <= 1'b1;
    end else if (state_r == ST_WAIT && pins.fault) begin
      drv_r <= 1'b0;
    end else if (end_ok) begin
      drv_r <= !pins.halt;
    end
  end

  // details of the failed access, caught when the fault is recognised
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      flt_addr_r <= 20'h00000;
      flt_fc_r   <= 3'h0;
      flt_wr_r   <= 1'b0;
      flt_ir_r   <= 16'h0000;
    end else if (state_r == ST_WAIT && pins.fault) begin
      flt_addr_r <= cur_r.addr;
      flt_fc_r   <= cur_r.fc;
      flt_wr_r   <= cur_r.write | rmw_wr_r;
      flt_ir_r   <= exc_ir_i;
    end
  end

  // exception sequence position; re-runs never enter here
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      exc_r     <= 1'b0;
      exc_idx_r <= 5'h00;
    end else if (state_r == ST_FAULT && !as_r && !pins.fault && !rerun_r
                 && !flt_flag_r && !boot_r) begin
      exc_r     <= 1'b1;
      exc_idx_r <= 5'h00;
    end else if (exc_r && end_ok) begin
      if (last_exc) begin
        exc_r <= 1'b0;
      end else begin
        exc_idx_r <= exc_idx_r + 5'h01;
      end
    end
  end

  // double fault flag: set at exception start wins over instruction start
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      flt_flag_r <= 1'b0;
    end else if (state_r == ST_FAULT && !as_r && !pins.fault && !rerun_r) begin
      flt_flag_r <= 1'b1;
    end else if (insn_start_i) begin
      flt_flag_r <= 1'b0;
    end
  end

  // boot window: any fault before the first instruction is fatal unless it re-runs
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      boot_r <= 1'b1;
    end else if (insn_start_i) begin
      boot_r <= 1'b0;
    end
  end

  // vector bytes assembled high byte first, handler started after the last
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      vec_r <= 32'h00000000;
      go_r  <= 1'b0;
    end else begin
      go_r <= exc_r && end_ok && last_exc;
      if (exc_r && end_ok && exc_idx_r >= 5'(`BHC_FRAME_BYTES)) begin
        vec_r <= {vec_r[23:0], data_i};
      end
    end
  end

  // core completion and read data
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      done_r      <= 1'b0;
      cyc_rdata_o <= 8'h00;
    end else begin
      done_r <= end_ok && !exc_r;
      if (state_r == ST_WAIT && pins.ack && !pins.fault && !cur_r.write && !rmw_wr_r) begin
        cyc_rdata_o <= data_i;
      end
    end
  end

  // arbitration: granted between cycles, also while halted
  always_ff @(posedge mclk_i) begin
    if (rst_all) begin
      grant_r <= 1'b0;
    end else if (!bus_req_i) begin
      grant_r <= 1'b0;
    end else if ((state_r == ST_IDLE || state_r == ST_RERUN ||
                  state_r == ST_DFAULT) && !as_r && !start) begin
      grant_r <= 1'b1;
    end
  end

  // pin and core outputs
  assign addr_o             = cur_r.addr;
  assign addr_oe_o          = drv_r;
  assign data_o             = cur_r.data;
  assign data_oe_o          = drv_r && (cur_r.write || rmw_wr_r);
  assign fc_o               = cur_r.fc;
  assign rw_o               = !(cur_r.write || rmw_wr_r);
  assign address_strobe_n_o = !as_r;
  assign ctl_oe_o           = !grant_r;
  assign halt_n_o           = 1'b0;
  assign halt_oe_o          = (state_r == ST_DFAULT);
  assign dfault_o           = (state_r == ST_DFAULT);
  assign bus_grant_o        = grant_r;
  assign cyc_done_o         = done_r;
  assign handler_go_o       = go_r;
  assign handler_pc_o       = vec_r;
endmodule

// >>> verif/bhc_props.sv
// concurrent checks on the pins of the bus fault and halt control block
`timescale 1ns/1ps
module bhc_props (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cyc_req_i,
  input wire logic cyc_ack_o,
  input wire logic cyc_done_o,
  input wire logic dfault_o,
  input wire logic core_rst_o,
  input wire logic bus_grant_o,
  input wire logic addr_oe_o,
  input wire logic data_oe_o,
  input wire logic address_strobe_n_o,
  input wire logic transfer_acknowledge_n_i,
  input wire logic bus_fault_in_n_i,
  input wire logic halt_n_i,
  input wire logic halt_n_o,
  input wire logic halt_oe_o,
  input wire logic reset_n_i
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  logic [3:0] rh_r;
  // saturating count of samples with reset and halt pins both low
  always_ff @(posedge mclk_i) begin
    if (rst_i || reset_n_i || halt_n_i) begin
      rh_r <= 4'h0;
    end else if (rh_r != 4'hF) begin
      rh_r <= rh_r + 4'h1;
    end
  end
  sequence s_flt_held;
    !bus_fault_in_n_i [*5];
  endsequence
  sequence s_halt_held;
    !halt_n_i [*4];
  endsequence
  a_fault_floats: assert property (s_flt_held |-> !addr_oe_o && !data_oe_o)
    else $error("bus driven under a held fault");
  a_strobe_neg: assert property ($fell(bus_fault_in_n_i) && !address_strobe_n_o
    |-> ##[2:6] address_strobe_n_o) else $error("strobe not negated after fault");
  a_halt_idle: assert property (s_halt_held ##0 address_strobe_n_o
    |=> address_strobe_n_o) else $error("cycle started while halted");
  a_take_gate: assert property (cyc_ack_o |-> cyc_req_i && !dfault_o && !bus_grant_o)
    else $error("request taken when it must be refused");
  a_take_runs: assert property (cyc_ack_o |-> ##[1:3] !address_strobe_n_o)
    else $error("taken request did not start a cycle");
  a_done_cause: assert property (cyc_done_o |-> !$past(transfer_acknowledge_n_i, 1)
    || !$past(transfer_acknowledge_n_i, 2) || !$past(transfer_acknowledge_n_i, 3))
    else $error("done without acknowledge");
  a_dfault_hold: assert property (dfault_o && !core_rst_o |=> dfault_o)
    else $error("double fault left without reset");
  a_dfault_halt: assert property (dfault_o [*3] |-> halt_oe_o && !halt_n_o
    && address_strobe_n_o) else $error("double fault not halted");
  a_core_rst: assert property (rh_r == 4'hA |-> ##[0:4] core_rst_o)
    else $error("reset with halt gave no core reset");
endmodule
bind bhc_ctrl bhc_props bhc_props_inst (.mclk_i, .rst_i, .cyc_req_i, .cyc_ack_o, .cyc_done_o,
  .dfault_o, .core_rst_o, .bus_grant_o, .addr_oe_o, .data_oe_o, .address_strobe_n_o,
  .transfer_acknowledge_n_i, .bus_fault_in_n_i, .halt_n_i, .halt_n_o, .halt_oe_o, .reset_n_i);

// >>> verif/bhc_far.sv
// far side model: byte slave with optional bus fault answer
`timescale 1ns/1ps
module bhc_far (
  input  wire logic        mclk_i,
  input  wire logic        as_n_i,
  input  wire logic        rw_i,
  input  wire logic [19:0] addr_i,
  input  wire logic [7:0]  wd_i,
  input  wire logic        flt_i,
  output logic             ack_n_o,
  output logic             flt_n_o,
  output logic [7:0]       rd_o
);
  logic [19:0] wa[$];
  logic [7:0]  wd[$];
  int          cnt;
  int          fc;
  initial begin
    ack_n_o = 1'b1;
    flt_n_o = 1'b1;
    rd_o = 8'h00;
    cnt = 0;
    fc = 0;
  end
  // answers two waits after strobe; released data toggles so stale reads show up
  always @(negedge mclk_i) begin
    if (fc != 0) fc--;
    if (as_n_i) begin
      cnt = 0;
      rd_o = ~rd_o;
      ack_n_o = 1'b1;
    end else if (cnt == 2 && flt_i && fc == 0) begin
      fc = 6;
      cnt = 99; // a faulted strobe gets no late acknowledge
    end else if (cnt == 2) begin
      ack_n_o = 1'b0;
      rd_o = addr_i[7:0] ^ 8'h5A;
      if (!rw_i) wa.push_back(addr_i);
      if (!rw_i) wd.push_back(wd_i);
    end else if (cnt == 4) begin
      ack_n_o = 1'b1;
      cnt = -1; // rmw write half gets a fresh acknowledge
    end
    if (!as_n_i) cnt++;
    flt_n_o = (fc == 0);
  end
endmodule

// >>> verif/bus_error_halt_control_tb.sv
// self-checking bench for the bus fault and halt control block
`timescale 1ns/1ps
module bus_error_halt_control_tb;
  import bhc_pkg::*;
  logic        mclk_i;
  logic        rst_i;
  logic        cyc_req_i;
  bhc_cyc_s    cyc_i;
  logic        cyc_ack_o;
  logic        cyc_done_o;
  logic [7:0]  cyc_rdata_o;
  logic        insn_start_i;
  logic        reset_insn_i;
  logic [31:0] handler_pc_o;
  logic        handler_go_o;
  logic        dfault_o;
  logic        core_rst_o;
  logic [19:0] addr_o;
  logic        addr_oe_o;
  logic [7:0]  data_o;
  logic        rw_o;
  logic        as_n;
  logic        ack_n;
  logic        flt_n;
  logic [7:0]  rd;
  logic        halt_n_o;
  logic        halt_oe_o;
  logic        reset_n_o;
  logic        reset_oe_o;
  logic        halt_ext;
  logic        rst_ext;
  logic        flt;
  logic        bus_req_i;
  logic        bus_grant_o;
  logic        ctl_oe_o;
  logic [2:0]  fc_o;
  int          ngo;
  wire         halt_n_w = (halt_oe_o && !halt_n_o) ? 1'b0 : halt_ext;
  wire         reset_n_w = (reset_oe_o && !reset_n_o) ? 1'b0 : rst_ext;
  int          n_fail;
  int          compares;
  int          ndone;
  int          nack;
  int          ncore;
  int          k;
  int          n;
  bhc_ctrl bhc_ctrl_inst (.mclk_i, .rst_i, .cyc_req_i, .cyc_i, .cyc_ack_o, .cyc_done_o,
    .cyc_rdata_o, .exc_pc_i(32'h00001234), .exc_sr_i(16'h2700), .exc_ir_i(16'h4E71),
    .exc_sp_i(20'h01000), .insn_start_i, .reset_insn_i, .handler_pc_o, .handler_go_o,
    .dfault_o, .core_rst_o, .bus_req_i, .bus_grant_o, .addr_o, .addr_oe_o,
    .data_i(rd), .data_o, .data_oe_o(), .fc_o, .rw_o, .address_strobe_n_o(as_n),
    .ctl_oe_o, .transfer_acknowledge_n_i(ack_n), .bus_fault_in_n_i(flt_n),
    .halt_n_i(halt_n_w), .halt_n_o, .halt_oe_o, .reset_n_i(reset_n_w), .reset_n_o,
    .reset_oe_o);
  bhc_far bhc_far_inst (.mclk_i, .as_n_i(as_n), .rw_i(rw_o), .addr_i(addr_o),
    .wd_i(data_o), .flt_i(flt), .ack_n_o(ack_n), .flt_n_o(flt_n), .rd_o(rd));
  // 100 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // event counters read before the edge's own updates land
  always @(posedge mclk_i) begin
    if (cyc_done_o === 1'b1) ndone++;
    if (cyc_ack_o === 1'b1) nack++;
    if (core_rst_o === 1'b1) ncore++;
    if (handler_go_o === 1'b1) ngo++;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int c);
    repeat (c) @(negedge mclk_i);
  endtask
  task do_reset;
    rst_i = 1'b1;
    cyc(6);
    rst_i = 1'b0;
    cyc(2);
  endtask
  // request held through the take edge, seen by the edge counter; write data from the address
  task req(input logic [19:0] a, input logic w, input logic m);
    int n0;
    cyc(1);
    n0 = nack;
    cyc_i = '{addr: a, data: a[7:0] ^ 8'h33, fc: 3'h1, write: w, rmw: m};
    cyc_req_i = 1'b1;
    for (k = 0; k < 40 && nack == n0; k++) cyc(1);
    cyc_req_i = 1'b0;
  endtask
  task t_boot;
    flt = 1'b1;
    req(20'h00500, 1'b0, 1'b0);
    for (k = 0; k < 100 && dfault_o !== 1'b1; k++) cyc(1);
    flt = 1'b0;
    cyc(20);
    chk(dfault_o, 1'b1);
    do_reset;
    chk(dfault_o, 1'b0);
    $display("end of boot fault test");
  endtask
  task t_rw;
    ndone = 0;
    req(20'h00789, 1'b0, 1'b1);
    req(20'h00123, 1'b0, 1'b0);
    req(20'h00456, 1'b1, 1'b0);
    cyc(10);
    chk(ndone, 3);
    chk(cyc_rdata_o, 8'h79);
    chk(bhc_far_inst.wd[0], 8'hBA);
    chk(bhc_far_inst.wd[1], 8'h65);
    $display("end of read write test");
  endtask
  // fault with halt: plain cycles re-run, rmw takes the exception instead
  task t_rerun(input logic m);
    ndone = 0;
    ngo = 0;
    bhc_far_inst.wa.delete();
    bhc_far_inst.wd.delete();
    flt = 1'b1;
    req(20'h00300, 1'b1, m);
    halt_ext = 1'b0;
    for (k = 0; k < 20 && flt_n !== 1'b0; k++) cyc(1);
    flt = 1'b0;
    for (k = 0; k < 20 && flt_n !== 1'b1; k++) cyc(1);
    cyc(1);
    halt_ext = 1'b1;
    cyc(200);
    chk(ndone, {31'h0, !m});
    chk(bhc_far_inst.wa.size(), m ? 14 : 1);
    chk(bhc_far_inst.wd[0], m ? 8'h34 : 8'h33);
    if (m) chk(bhc_far_inst.wa[13], 20'h00FF2);
    if (m) chk(handler_pc_o, 32'h52535051);
    chk(ngo, {31'h0, m});
    chk(fc_o, m ? 3'h6 : 3'h1);
    chk(dfault_o, 1'b0);
    $display("end of re-run test");
  endtask
  task t_step;
    halt_ext = 1'b0;
    cyc(3);
    nack = 0;
    ndone = 0;
    cyc_i = '{addr: 20'h00600, data: 8'h00, fc: 3'h1, write: 1'b0, rmw: 1'b0};
    cyc_req_i = 1'b1;
    cyc(20);
    chk(nack, 0);
    halt_ext = 1'b1;
    for (k = 0; k < 20 && as_n !== 1'b0; k++) cyc(1);
    halt_ext = 1'b0;
    cyc(30);
    chk(nack, 1);
    chk(ndone, 1);
    chk(addr_oe_o, 1'b0);
    bus_req_i = 1'b1;
    cyc(3);
    chk(bus_grant_o, 1'b1);
    chk(ctl_oe_o, 1'b0);
    bus_req_i = 1'b0;
    cyc(2);
    chk(bus_grant_o, 1'b0);
    cyc_req_i = 1'b0;
    halt_ext = 1'b1;
    cyc(2);
    $display("end of single step test");
  endtask
  task t_rstpin;
    n = 0;
    reset_insn_i = 1'b1;
    cyc(1);
    reset_insn_i = 1'b0;
    for (k = 0; k < 200; k++) begin
      if (reset_n_w === 1'b0) n++;
      cyc(1);
    end
    chk(n, 124);
    ncore = 0;
    rst_ext = 1'b0;
    halt_ext = 1'b0;
    cyc(14);
    rst_ext = 1'b1;
    halt_ext = 1'b1;
    cyc(4);
    chk(ncore, 1);
    $display("end of reset line test");
  endtask
  task t_dbl;
    insn_start_i = 1'b1;
    cyc(1);
    insn_start_i = 1'b0;
    nack = 0;
    flt = 1'b1;
    req(20'h00400, 1'b0, 1'b0);
    for (k = 0; k < 100 && dfault_o !== 1'b1; k++) cyc(1);
    flt = 1'b0;
    req(20'h00410, 1'b0, 1'b0);
    chk(dfault_o, 1'b1);
    chk(halt_n_w, 1'b0);
    chk(nack, 1);
    do_reset;
    chk(dfault_o, 1'b0);
    $display("end of double fault test");
  endtask
  task conclude;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog at ten thousand cycles, well beyond the expected run of about a thousand
  initial begin
    #100000;
    n_fail++;
    conclude;
  end
  initial begin
    cyc_req_i = 1'b0;
    bus_req_i = 1'b0;
    cyc_i = '0;
    insn_start_i = 1'b0;
    reset_insn_i = 1'b0;
    halt_ext = 1'b1;
    rst_ext = 1'b1;
    flt = 1'b0;
    n_fail = 0;
    compares = 0;
    do_reset;
    t_boot;
    t_rw;
    insn_start_i = 1'b1;
    cyc(1);
    insn_start_i = 1'b0;
    t_rerun(1'b0);
    t_rerun(1'b0);
    t_rerun(1'b1);
    t_step;
    t_rstpin;
    t_dbl;
    conclude;
  end
endmodule
